// file: design/bac_pkg.sv
// ****************************************************************
// Shared constants and carriers for the burst address counter port
// ****************************************************************
package bac_pkg;

  // Address and data widths of one port.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned LANES  = 2;

  // Values after reset.
  localparam logic [ADDR_W-1:0] CNT_RST_VAL  = 16'h0000;
  localparam logic [ADDR_W-1:0] MASK_RST_VAL = 16'hffff;  // Unmasked: every bit counts.
  localparam logic [DATA_W-1:0] DATA_RST_VAL = 18'h00000;

  // Length of the wrap pulse in clock cycles.
  localparam int unsigned WRAP_PULSE_CYC = 1;

  // Active-low counter and mask controls, sampled on the port clock.
  typedef struct packed {
    logic addr_counter_clear_n;
    logic addr_counter_load_n;
    logic addr_counter_step_n;
    logic addr_counter_readback_n;
    logic wrap_mask_load_n;
    logic wrap_mask_readback_n;
  } bac_ctl_t;

  // Access controls of the port.
  typedef struct packed {
    logic port_select_low_n;
    logic port_select_high;
    logic read_not_write;
    logic low_lane_select_n;
    logic high_lane_select_n;
  } bac_acc_t;

  // Control word that does nothing; used for reset deselect.
  localparam bac_ctl_t CTL_IDLE = 6'h3f;

endpackage

// file: design/bac_port.sv
`timescale 1ns/1ps
// How it works
// - Data pins driven only while output enable is low during a read.
// - Output enable gates the data drivers combinationally, without a clock edge.
// - Counter load low captures the address lines into the counter.
// - Counter step low advances the counter at every rising clock edge.
// - Stepping follows the mask; the unmasked default steps by one.
// - Counter readback low drives the counter value onto the address lines.
// - Counter readback ignores both port selects.
// - Enabled counter readback also reads the word at the counter address.
// - Counter clear low sets the counter to zero.
// - Wrap pulse goes low when a step wraps the masked counter to minimum.
// - Wrap pulse lasts one cycle and returns high by itself.
// - Mask load low captures the address lines into the mask register.
// - Mask readback low drives the mask onto the address lines.
// - Mask readback ignores both port selects.
// - Enabled mask readback reads the word at the presented address.
// - Port is active only with select-low low and select-high high.
// - Global init clears counter, unmasks mask, resets pulse, deselects controls.
// - Low lane gates bits 0 to 8, high lane bits 9 to 17.
module bac_port
  import bac_pkg::*;
(
  // Clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 global_init_n,
  // Port controls from the host.
  input  wire bac_pkg::bac_ctl_t    ctl_n,
  input  wire bac_pkg::bac_acc_t    acc,
  input  wire logic                 output_enable_n,
  // Address lines, split into input, output and enable.
  input  wire logic [bac_pkg::ADDR_W-1:0] addr_in,
  output logic [bac_pkg::ADDR_W-1:0]      addr_out,
  output logic                      addr_oe_n,
  // Data lines toward the host.
  output logic [bac_pkg::DATA_W-1:0]      data_out,
  output logic [bac_pkg::LANES-1:0]       data_oe_n,
  // Memory core side.
  output logic [bac_pkg::ADDR_W-1:0]      array_addr,
  output logic                      array_read,
  input  wire logic [bac_pkg::DATA_W-1:0] array_rdata,
  // Counter wrap event.
  output logic                      wrap_pulse_n
);
  import bac_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Masked increment: bits outside the mask are forced to one so the carry jumps
  // over them, then the original values are put back in place.
  function automatic logic [ADDR_W-1:0] masked_step(input logic [ADDR_W-1:0] cnt,
                                                    input logic [ADDR_W-1:0] mask);
    logic [ADDR_W-1:0] sum;
    sum = (cnt | ~mask) + 16'h0001;
    return (sum & mask) | (cnt & ~mask);
  endfunction

  // The masked part is at its maximum, so the next step wraps.
  function automatic logic at_wrap(input logic [ADDR_W-1:0] cnt,
                                   input logic [ADDR_W-1:0] mask);
    return (cnt & mask) == mask;
  endfunction

  // ****************************************************************
  // Master reset synchroniser
  // ****************************************************************

  logic init_meta_q;
  logic init_sync_q;
  logic init_meta_d;
  logic init_sync_d;

  // The init pin is asynchronous, so it passes two flops before use.
  always_comb begin
    init_meta_d = global_init_n;
    init_sync_d = init_meta_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      init_meta_q <= 1'b1;
      init_sync_q <= 1'b1;
    end else begin
      init_meta_q <= init_meta_d;
      init_sync_q <= init_sync_d;
    end
  end

  // ****************************************************************
  // Counter, mask and wrap pulse
  // ****************************************************************

  logic [ADDR_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] mask_q, mask_d;
  logic              wrap_n_q, wrap_n_d;
  bac_ctl_t          ctl_q, ctl_d;
  bac_acc_t          acc_q, acc_d;
  logic              port_on;

  assign port_on = !acc.port_select_low_n && acc.port_select_high;

  // Next counter, mask and pulse values.
  always_comb begin
    cnt_d    = cnt_q;
    mask_d   = mask_q;
    wrap_n_d = 1'b1;
    ctl_d    = ctl_n;
    acc_d    = acc;
    if (!ctl_n.addr_counter_clear_n) begin
      cnt_d = CNT_RST_VAL;
    end else if (!ctl_n.addr_counter_load_n) begin
      cnt_d = addr_in;
    end else if (!ctl_n.addr_counter_step_n) begin
      cnt_d = masked_step(cnt_q, mask_q);
      wrap_n_d = !at_wrap(cnt_q, mask_q);
    end
    if (!ctl_n.wrap_mask_load_n) begin
      mask_d = addr_in;
    end
    if (!init_sync_q) begin
      cnt_d    = CNT_RST_VAL;
      mask_d   = MASK_RST_VAL;
      wrap_n_d = 1'b1;
      ctl_d    = CTL_IDLE;
      acc_d.port_select_low_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q    <= CNT_RST_VAL;
      mask_q   <= MASK_RST_VAL;
      wrap_n_q <= 1'b1;
      ctl_q    <= CTL_IDLE;
      acc_q    <= '1;
    end else begin
      cnt_q    <= cnt_d;
      mask_q   <= mask_d;
      wrap_n_q <= wrap_n_d;
      ctl_q    <= ctl_d;
      acc_q    <= acc_d;
    end
  end

  assign wrap_pulse_n = wrap_n_q;

  // ****************************************************************
  // Address line readback and array access
  // ****************************************************************

  logic [ADDR_W-1:0] arr_addr_q, arr_addr_d;
  logic              arr_rd_q, arr_rd_d;
  logic              rd_q, rd_d;
  logic [DATA_W-1:0] data_q, data_d;

  always_comb begin
    addr_oe_n = ctl_q.addr_counter_readback_n && ctl_q.wrap_mask_readback_n;
    addr_out  = !ctl_q.addr_counter_readback_n ? cnt_q : mask_q;
  end

  // Address for the core: counter readback uses the counter, mask readback
  // uses the presented address, ordinary cycles use the next counter value.
  always_comb begin
    if (!ctl_n.addr_counter_readback_n) begin
      arr_addr_d = cnt_q;
    end else if (!ctl_n.wrap_mask_readback_n) begin
      arr_addr_d = addr_in;
    end else begin
      arr_addr_d = cnt_d;
    end
    arr_rd_d = port_on && acc.read_not_write && init_sync_q;
    rd_d     = arr_rd_q;
    data_d   = arr_rd_q ? array_rdata : data_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arr_addr_q <= CNT_RST_VAL;
      arr_rd_q   <= 1'b0;
      rd_q       <= 1'b0;
      data_q     <= DATA_RST_VAL;
    end else begin
      arr_addr_q <= arr_addr_d;
      arr_rd_q   <= arr_rd_d;
      rd_q       <= rd_d;
      data_q     <= data_d;
    end
  end

  assign array_addr = arr_addr_q;
  assign array_read = arr_rd_q;
  assign data_out   = data_q;

  // Lane drivers stay combinational on output enable so that releasing the
  // bus never waits for a clock; the price is that a glitch on the pin shows.
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic lane_sel_n;
      assign lane_sel_n = (g == 0) ? acc_q.low_lane_select_n : acc_q.high_lane_select_n;
      assign data_oe_n[g] = !(rd_q && !lane_sel_n && !output_enable_n);
    end
  endgenerate

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_clear_zero;
    !ctl_n.addr_counter_clear_n && init_sync_q |=> cnt_q == CNT_RST_VAL;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");

  property p_load_over_step;
    ctl_n.addr_counter_clear_n && !ctl_n.addr_counter_load_n && init_sync_q
      |=> cnt_q == $past(addr_in);
  endproperty
  a_load_over_step: assert property (p_load_over_step) else $error("load lost");

  property p_step_one;
    ctl_n.addr_counter_clear_n && ctl_n.addr_counter_load_n && !ctl_n.addr_counter_step_n
      && init_sync_q && mask_q == MASK_RST_VAL
      |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_step_one: assert property (p_step_one) else $error("step not by one");

  property p_hold;
    ctl_n.addr_counter_clear_n && ctl_n.addr_counter_load_n && ctl_n.addr_counter_step_n
      && init_sync_q |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while idle");

  property p_wrap_pulse;
    !wrap_pulse_n |-> $past(at_wrap(cnt_q, mask_q)) && $past(!ctl_n.addr_counter_step_n)
      ##1 wrap_pulse_n || $past(at_wrap(cnt_q, mask_q));
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse bad");

  property p_wrap_zero;
    $fell(wrap_pulse_n) |-> (cnt_q & mask_q) == 16'h0000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap not to min");

  property p_mask_load;
    !ctl_n.wrap_mask_load_n && init_sync_q |=> mask_q == $past(addr_in);
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

  property p_cnt_readback;
    !ctl_n.addr_counter_readback_n && init_sync_q |=> !addr_oe_n && addr_out == cnt_q;
  endproperty
  a_cnt_readback: assert property (p_cnt_readback) else $error("counter readback bad");

  property p_init;
    !init_sync_q |=> cnt_q == CNT_RST_VAL && mask_q == MASK_RST_VAL && wrap_pulse_n;
  endproperty
  a_init: assert property (p_init) else $error("init did not reset");

  property p_oe_gate;
    !data_oe_n[0] |-> !output_enable_n && $past(array_read) && !acc_q.low_lane_select_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("data driven without enable");

endmodule

// file: dv/bac_host_model.sv
`timescale 1ns/1ps
// ****************************************************
// Host address pads and a stand-in for the memory core
// ****************************************************
module bac_host_model
  import bac_pkg::*;
(
  // Clock.
  input  wire logic                       sys_clk,
  // Host and device address drivers.
  input  wire logic [bac_pkg::ADDR_W-1:0] host_addr,
  input  wire logic                       host_drive,
  input  wire logic [bac_pkg::ADDR_W-1:0] addr_out,
  input  wire logic                       addr_oe_n,
  output logic [bac_pkg::ADDR_W-1:0]      addr_wire,
  // Memory core.
  input  wire logic [bac_pkg::ADDR_W-1:0] array_addr,
  output logic [bac_pkg::DATA_W-1:0]      array_rdata
);
  logic [ADDR_W-1:0] last_q = 16'h0000;

  // resolved address wire
  // A released wire shows a changing pattern, so a stale value cannot pass.
  always_comb begin
    if (addr_oe_n === 1'b0) addr_wire = addr_out;
    else if (host_drive) addr_wire = host_addr;
    else addr_wire = ~last_q;
  end

  // Remember the wire level for the float pattern.
  always @(posedge sys_clk) last_q <= addr_wire;

  // The core answers with a word derived from its address.
  assign array_rdata = {2'h2, array_addr ^ 16'h5a5a};
endmodule

// file: dv/test_burst_address_counter_port.sv
`timescale 1ns/1ps
module test_burst_address_counter_port;
  import bac_pkg::*;
  localparam logic [5:0] CLR = 6'h20, LD = 6'h10, STP = 6'h08;
  localparam logic [5:0] CRD = 6'h04, MLD = 6'h02, MRD = 6'h01;
  logic sys_clk = 0, rst_n = 0, global_init_n = 1, output_enable_n = 1;
  logic host_drive = 1, addr_oe_n, array_read, wrap_pulse_n, prev_oe = 1, prev_wrap = 1;
  bac_ctl_t ctl_n = CTL_IDLE;
  bac_acc_t acc = 5'h1b;
  logic [ADDR_W-1:0] host_addr = 16'h0000, addr_wire, addr_out, array_addr, a;
  logic [DATA_W-1:0] data_out, array_rdata;
  logic [LANES-1:0] data_oe_n;
  logic [ADDR_W-1:0] exp_addr[$];
  bit exp_wrap[$];
  int miscompares = 0, n_compared = 0, seed = 81, cycles = 0, n;

  always #5 sys_clk = ~sys_clk;

  bac_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .global_init_n(global_init_n),
    .ctl_n(ctl_n), .acc(acc), .output_enable_n(output_enable_n), .addr_in(addr_wire),
    .addr_out(addr_out), .addr_oe_n(addr_oe_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .array_addr(array_addr), .array_read(array_read),
    .array_rdata(array_rdata), .wrap_pulse_n(wrap_pulse_n));

  bac_host_model host (.sys_clk(sys_clk), .host_addr(host_addr), .host_drive(host_drive),
    .addr_out(addr_out), .addr_oe_n(addr_oe_n), .addr_wire(addr_wire),
    .array_addr(array_addr), .array_rdata(array_rdata));

  task automatic chk_addr(string what, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (e !== s) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic chk_flag(string what, logic [1:0] e, logic [1:0] s);
    n_compared++;
    if (e !== s) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", what, e, s);
    end
  endtask

  // Compares one read data word.
  task automatic chk_data(string what, logic [17:0] e, logic [17:0] s);
    n_compared++;
    if (e !== s) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  // Holds the given controls low for n sampling edges, then idles them.
  task automatic op(logic [5:0] low, logic [15:0] addr, int n);
    @(posedge sys_clk);
    ctl_n <= bac_ctl_t'(~low);
    host_addr <= addr;
    host_drive <= ((low & (CRD | MRD)) == 6'h00);
    repeat (n) @(posedge sys_clk);
    ctl_n <= CTL_IDLE;
    host_drive <= 1'b1;
  endtask

  // Readback with the port selects left as they are; the monitor checks the value.
  task automatic rdback(logic mask, logic [15:0] e);
    exp_addr.push_back(e);
    repeat (2) @(posedge sys_clk);
    op(mask ? MRD : CRD, 16'h0000, 3);
    repeat (2) @(posedge sys_clk);
  endtask

  // Results are taken off the queues as they show up at the outputs.
  always @(negedge sys_clk) begin
    if (addr_oe_n === 1'b0 && prev_oe === 1'b1) begin
      chk_addr("readback_pending", 16'h0001, 16'(exp_addr.size() != 0));
      if (exp_addr.size() != 0) chk_addr("readback", exp_addr.pop_front(), addr_out);
    end
    if (wrap_pulse_n === 1'b0) begin
      chk_flag("wrap_expected", 2'h1, 2'(exp_wrap.size() != 0));
      chk_flag("wrap_width", 2'h1, {1'b0, prev_wrap});
      if (exp_wrap.size() != 0) void'(exp_wrap.pop_front());
    end
    prev_oe <= addr_oe_n;
    prev_wrap <= wrap_pulse_n;
  end

  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // A hung handshake must not stall the run.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    op(LD | MLD, 16'h0f0f, 1);
    @(posedge sys_clk);
    global_init_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    global_init_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdback(1'b0, CNT_RST_VAL);
    rdback(1'b1, MASK_RST_VAL);
    for (int i = 0; i < 4; i++) begin
      a = 16'($random(seed)) & 16'h0fff;
      n = 1 + ($unsigned($random(seed)) % 5);
      op(LD, a, 1);
      op(STP, 16'h0000, n);
      rdback(1'b0, a + 16'(n));
    end
    op(CLR | LD, 16'h1234, 1);
    rdback(1'b0, 16'h0000);
    op(LD | STP, 16'h0042, 1);
    rdback(1'b0, 16'h0042);
    op(LD, 16'hffff, 1);
    exp_wrap.push_back(1'b1);
    op(STP, 16'h0000, 1);
    rdback(1'b0, 16'h0000);
    op(MLD, 16'h000f, 1);
    rdback(1'b1, 16'h000f);
    op(LD, 16'h000e, 1);
    op(STP, 16'h0000, 1);
    repeat (3) @(posedge sys_clk);
    exp_wrap.push_back(1'b1);
    op(STP, 16'h0000, 1);
    repeat (3) @(posedge sys_clk);
    op(MLD, 16'hffff, 1);
    chk_flag("wrap_left", 2'h0, 2'(exp_wrap.size()));
    // Every lane combination with the port enabled for reads; the counter sits at zero.
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      acc <= {1'b0, 1'b1, 1'b1, i[0], i[1]};
      output_enable_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk_flag("lanes", {i[1], i[0]}, data_oe_n);
      chk_flag("array_read", 2'h1, {1'b0, array_read});
      chk_data("read_data", {2'h2, 16'h5a5a}, data_out);
    end
    // Enabled counter readback leaves the core reading the counter address.
    op(LD, 16'h0123, 1);
    rdback(1'b0, 16'h0123);
    chk_addr("array_addr", 16'h0123, array_addr);
    chk_data("readback_data", {2'h2, 16'h0123 ^ 16'h5a5a}, data_out);
    // Both lanes on, then output enable raised at an edge must release them at once.
    @(posedge sys_clk);
    acc <= 5'h0c;
    output_enable_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk_flag("lanes_on", 2'h0, data_oe_n);
    output_enable_n <= 1'b1;
    #2 chk_flag("oe_async", 2'h3, data_oe_n);
    @(posedge sys_clk);
    output_enable_n <= 1'b0;
    acc <= 5'h08;
    repeat (3) @(posedge sys_clk);
    chk_flag("write_lanes", 2'h3, data_oe_n);
    chk_flag("write_read", 2'h0, {1'b0, array_read});
    acc <= 5'h04;
    repeat (3) @(posedge sys_clk);
    chk_flag("off_lanes", 2'h3, data_oe_n);
    chk_flag("off_read", 2'h0, {1'b0, array_read});
    stop_test();
  end
endmodule
